// file: include/wwdsup_pkg.sv
// Purpose: shared constants and types for the window watchdog supervisor
// Assumes: 40 MHz core clock, 10 us internal timing tick
// Notes:   window figures are typical values; all counts except TICK_CYCLES are in ticks
package wwdsup_pkg;

  // ----------------------------------------------------------------------
  // clock and tick
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_US = 10;
  localparam int TICK_CYCLES = TICK_US * 1000000 / CLK_PERIOD_PS;
  localparam int TICK_W = 12;

  // ----------------------------------------------------------------------
  // window times in microseconds, as printed
  // ----------------------------------------------------------------------
  localparam int WIN_SHORT_US = 250000;
  localparam int WIN_LONG_US = 2500000;
  localparam int LOW_SHORT_COARSE_US = 7860;
  localparam int LOW_SHORT_FINE_US = 2000;
  localparam int LOW_LONG_COARSE_US = 78200;
  localparam int LOW_LONG_FINE_US = 19600;
  localparam int CAP_STEP_US = 6250;
  localparam int RELEASE_US = 25000;

  // ----------------------------------------------------------------------
  // tick counts: upper limits round down, lower boundaries round up
  // ----------------------------------------------------------------------
  localparam int WIN_W = 22;
  localparam int CAP_W = 12;
  localparam logic [WIN_W-1:0] WIN_SHORT_TICKS = WIN_W'(WIN_SHORT_US / TICK_US);
  localparam logic [WIN_W-1:0] WIN_LONG_TICKS = WIN_W'(WIN_LONG_US / TICK_US);
  localparam logic [WIN_W-1:0] LOW_SHORT_COARSE_TICKS =
    WIN_W'((LOW_SHORT_COARSE_US + TICK_US - 1) / TICK_US);
  localparam logic [WIN_W-1:0] LOW_SHORT_FINE_TICKS =
    WIN_W'((LOW_SHORT_FINE_US + TICK_US - 1) / TICK_US);
  localparam logic [WIN_W-1:0] LOW_LONG_COARSE_TICKS =
    WIN_W'((LOW_LONG_COARSE_US + TICK_US - 1) / TICK_US);
  localparam logic [WIN_W-1:0] LOW_LONG_FINE_TICKS =
    WIN_W'((LOW_LONG_FINE_US + TICK_US - 1) / TICK_US);
  localparam logic [WIN_W-1:0] CAP_STEP_TICKS = WIN_W'(CAP_STEP_US / TICK_US);
  localparam logic [WIN_W-1:0] RELEASE_TICKS = WIN_W'((RELEASE_US + TICK_US - 1) / TICK_US);

  // ----------------------------------------------------------------------
  // capacitor-mode ratios, divisor times ten, as fixed-point reciprocals
  // ----------------------------------------------------------------------
  localparam int RATIO_SHIFT = 16;
  localparam int RATIO_COARSE_X10 = 258;
  localparam int RATIO_FINE_X10 = 645;
  localparam logic [CAP_W-1:0] RATIO_COARSE_K =
    CAP_W'(((1 << RATIO_SHIFT) * 10 + RATIO_COARSE_X10 - 1) / RATIO_COARSE_X10);
  localparam logic [CAP_W-1:0] RATIO_FINE_K =
    CAP_W'(((1 << RATIO_SHIFT) * 10 + RATIO_FINE_X10 - 1) / RATIO_FINE_X10);

  // ----------------------------------------------------------------------
  // strap encodings and types
  // ----------------------------------------------------------------------
  localparam logic [1:0] TSEL_LOW = 2'h0;
  localparam logic [1:0] TSEL_HIGH = 2'h1;
  localparam logic [1:0] TSEL_CAP = 2'h2;

  typedef enum logic [1:0] {WWD_TM_SHORT, WWD_TM_LONG, WWD_TM_CAP} wwdsup_tmode_type;
  typedef enum logic [1:0] {WWD_HOLD, WWD_DELAY, WWD_WATCH} wwdsup_state_type;

endpackage

// file: include/wwdsup_link_if.sv
// Purpose: carries tick and synchronised pin events to the watchdog core
// Assumes: single core clock domain
// Notes:   one-cycle pulses on tick and trig_rise
`timescale 1ns/1ps
interface wwdsup_link_if;
  logic tick;
  logic trig_rise;
  logic supply_good;
  modport tb (output tick);
  modport sy (output trig_rise, output supply_good);
  modport core (input tick, input trig_rise, input supply_good);
endinterface

// file: core/wwdsup_timebase.sv
// Purpose: divides the core clock into the internal timing tick
// Assumes: tick_cycles at least 2
// Notes:   tick is a one-cycle enable, never a clock
`timescale 1ns/1ps
module wwdsup_timebase
  import wwdsup_pkg::*;
#(
  parameter int TICK_CYCLES_P = wwdsup_pkg::TICK_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  wwdsup_link_if.tb tb
);
  logic [TICK_W-1:0] div_r;
  logic tick_r;
  logic div_end;

  assign div_end = (div_r == TICK_W'(TICK_CYCLES_P - 1));
  assign tb.tick = tick_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div_r <= '0;
      tick_r <= 1'h0;
    end else begin
      div_r <= div_end ? '0 : div_r + TICK_W'(1);
      tick_r <= div_end;
    end
  end
endmodule

// file: core/wwdsup_sync.sv
// Purpose: brings trigger and supply-good pins into the core clock domain
// Assumes: pins are asynchronous to core_clk
// Notes:   a level change counts once stages two and three agree
`timescale 1ns/1ps
module wwdsup_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic trig_pin,
  input wire logic supply_pin,
  wwdsup_link_if.sy sy
);
  logic [1:0] pin_in;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] filt_r;
  logic [1:0] filt_nxt;
  logic rise_r;

  assign pin_in = {supply_pin, trig_pin};

  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_bit
      assign filt_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : filt_r[i];
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          s1_r[i] <= 1'h0;
          s2_r[i] <= 1'h0;
          s3_r[i] <= 1'h0;
          filt_r[i] <= 1'h0;
        end else begin
          s1_r[i] <= pin_in[i];
          s2_r[i] <= s1_r[i];
          s3_r[i] <= s2_r[i];
          filt_r[i] <= filt_nxt[i];
        end
      end
    end
  endgenerate

  // only the low-to-high edge retriggers the window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rise_r <= 1'h0;
    end else begin
      rise_r <= filt_nxt[0] & ~filt_r[0];
    end
  end

  assign sy.trig_rise = rise_r;
  assign sy.supply_good = filt_r[1];

  property p_rise_from_low;
    @(posedge core_clk) disable iff (rst) rise_r |-> $past(filt_r[0]) == 1'h0 && filt_r[0];
  endproperty
  a_rise_from_low: assert property (p_rise_from_low)
    else $error("trigger rise without edge");
endmodule

// file: core/wwdsup_top.sv
// Purpose: window watchdog with supply supervision and release delay
// Assumes: straps static, captured once after reset release
// Notes:   reset_n_r is the active-low supervisor reset, open-drain style
//
// Summary of operation
// - With supply good, reset stays high while each trigger lands inside the window.
// - A missing trigger by the upper limit or a trigger outside the window asserts reset.
// - A trigger before the lower boundary is a violation and asserts reset.
// - Below the supply threshold reset is held asserted whatever the trigger does.
// - Timeout strap low gives a 0.25 s window with 7.86 ms or 2 ms lower boundary.
// - Timeout strap high gives a 2.5 s window with 78.2 ms or 19.6 ms lower boundary.
// - Capacitor mode sets the upper window while the ratio strap sets the lower one.
// - Capacitor window is (capacitance / 15.55 pF + 1) steps of 6.25 ms.
// - The core runs free of the trigger source; a sampled rising edge reaches the window logic three cycles later.
// - Triggers in the tolerance zones have no guaranteed outcome and should be avoided.
// - A violation asserts reset for the 25 ms release delay and restarts the timer.
// - After release the lower boundary is off until the first rising trigger edge.
// - When supply returns, reset stays low for the release delay and then releases.
`timescale 1ns/1ps
module wwdsup_top #(
  parameter int TICK_CYCLES_P = wwdsup_pkg::TICK_CYCLES,
  parameter logic [wwdsup_pkg::WIN_W-1:0] SHORT_WIN = wwdsup_pkg::WIN_SHORT_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] LONG_WIN = wwdsup_pkg::WIN_LONG_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] SHORT_LOW_C = wwdsup_pkg::LOW_SHORT_COARSE_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] SHORT_LOW_F = wwdsup_pkg::LOW_SHORT_FINE_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] LONG_LOW_C = wwdsup_pkg::LOW_LONG_COARSE_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] LONG_LOW_F = wwdsup_pkg::LOW_LONG_FINE_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] CAP_STEP = wwdsup_pkg::CAP_STEP_TICKS,
  parameter logic [wwdsup_pkg::WIN_W-1:0] RELEASE = wwdsup_pkg::RELEASE_TICKS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic watchdog_trigger_in,
  input wire logic supply_threshold_ok,
  input wire logic [1:0] timeout_select_strap,
  input wire logic ratio_select_strap,
  input wire logic [wwdsup_pkg::CAP_W-1:0] cap_steps,
  output logic reset_n_r,
  output logic reset_oe_r,
  output logic lower_armed_r
);
  import wwdsup_pkg::*;

  // ----------------------------------------------------------------------
  // timing tick and pin synchronisers
  // ----------------------------------------------------------------------
  wwdsup_link_if lnk ();

  wwdsup_timebase #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_timebase (
    .core_clk(core_clk),
    .rst(rst),
    .tb(lnk.tb)
  );

  wwdsup_sync u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .trig_pin(watchdog_trigger_in),
    .supply_pin(supply_threshold_ok),
    .sy(lnk.sy)
  );

  // ----------------------------------------------------------------------
  // strap capture
  // ----------------------------------------------------------------------
  logic cfg_done_r;
  wwdsup_tmode_type tmode_r;
  wwdsup_tmode_type tmode_pin;
  logic ratio_fine_r;
  logic [CAP_W-1:0] cap_steps_r;

  // straps are only sampled once, so a floating strap cannot move the window later
  assign tmode_pin = (timeout_select_strap == TSEL_HIGH) ? WWD_TM_LONG :
                     (timeout_select_strap == TSEL_CAP) ? WWD_TM_CAP : WWD_TM_SHORT;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfg_done_r <= 1'h0;
      tmode_r <= WWD_TM_SHORT;
      ratio_fine_r <= 1'h0;
      cap_steps_r <= '0;
    end else if (!cfg_done_r) begin
      cfg_done_r <= 1'h1;
      tmode_r <= tmode_pin;
      ratio_fine_r <= ratio_select_strap;
      cap_steps_r <= cap_steps;
    end
  end

  // ----------------------------------------------------------------------
  // window limits
  // ----------------------------------------------------------------------
  logic [WIN_W-1:0] cap_upper;
  logic [WIN_W+3:0] cap_scaled;
  logic [WIN_W-1:0] cap_lower_c;
  logic [WIN_W-1:0] cap_lower_f;
  logic [WIN_W-1:0] cap_lower;
  logic [WIN_W-1:0] upper_lim;
  logic [WIN_W-1:0] lower_lim;

  assign cap_upper = WIN_W'((32'(cap_steps_r) + 32'd1) * 32'(CAP_STEP));
  // exact round-up divide by the ratio constants, so the boundary never comes
  // out shorter than the typical figure; costs two constant dividers
  assign cap_scaled = {4'h0, cap_upper} * (WIN_W+4)'(4'hA);
  assign cap_lower_c = WIN_W'((cap_scaled + (WIN_W+4)'(RATIO_COARSE_X10 - 1)) /
                              (WIN_W+4)'(RATIO_COARSE_X10));
  assign cap_lower_f = WIN_W'((cap_scaled + (WIN_W+4)'(RATIO_FINE_X10 - 1)) /
                              (WIN_W+4)'(RATIO_FINE_X10));
  assign cap_lower = ratio_fine_r ? cap_lower_f : cap_lower_c;

  assign upper_lim = (tmode_r == WWD_TM_LONG) ? LONG_WIN :
                     (tmode_r == WWD_TM_CAP) ? cap_upper : SHORT_WIN;
  assign lower_lim = (tmode_r == WWD_TM_CAP) ? cap_lower :
                     (tmode_r == WWD_TM_LONG) ? (ratio_fine_r ? LONG_LOW_F : LONG_LOW_C) :
                     (ratio_fine_r ? SHORT_LOW_F : SHORT_LOW_C);

  // ----------------------------------------------------------------------
  // window decisions
  // ----------------------------------------------------------------------
  wwdsup_state_type state_r;
  wwdsup_state_type state_nxt;
  logic [WIN_W-1:0] win_cnt_r;
  logic [WIN_W-1:0] win_cnt_nxt;
  logic [WIN_W-1:0] delay_cnt_r;
  logic [WIN_W-1:0] delay_cnt_nxt;
  logic lower_armed_nxt;
  logic watching;
  logic timeout_hit;
  logic early_hit;
  logic good_trig;
  logic violation;
  logic delay_done;
  logic supervise_ok;

  assign watching = (state_r == WWD_WATCH);
  assign supervise_ok = cfg_done_r & lnk.supply_good;
  // typical limits only: triggers near a limit resolve one way, unspecified to the user
  assign timeout_hit = watching && (win_cnt_r >= upper_lim);
  assign early_hit = watching && lnk.trig_rise && lower_armed_r && !timeout_hit &&
                     (win_cnt_r < lower_lim);
  assign good_trig = watching && lnk.trig_rise && !timeout_hit && !early_hit;
  assign violation = timeout_hit | early_hit;
  assign delay_done = (state_r == WWD_DELAY) && (delay_cnt_r >= RELEASE);

  always_comb begin
    state_nxt = state_r;
    if (!supervise_ok) begin
      state_nxt = WWD_HOLD;
    end else begin
      case (state_r)
        WWD_HOLD: state_nxt = WWD_DELAY;
        WWD_DELAY: if (delay_done) state_nxt = WWD_WATCH;
        WWD_WATCH: if (violation) state_nxt = WWD_DELAY;
        default: state_nxt = WWD_HOLD;
      endcase
    end
  end

  // the window counter saturates so a stuck count still reads as a timeout
  assign win_cnt_nxt = ((state_nxt != WWD_WATCH) || good_trig) ? '0 :
                       (lnk.tick && (win_cnt_r != '1)) ? win_cnt_r + WIN_W'(1) : win_cnt_r;
  assign delay_cnt_nxt = ((state_nxt != WWD_DELAY) || (state_r != WWD_DELAY)) ? '0 :
                         lnk.tick ? delay_cnt_r + WIN_W'(1) : delay_cnt_r;
  assign lower_armed_nxt = (state_nxt == WWD_WATCH) && (lower_armed_r || good_trig);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= WWD_HOLD;
      win_cnt_r <= '0;
      delay_cnt_r <= '0;
      lower_armed_r <= 1'h0;
    end else begin
      state_r <= state_nxt;
      win_cnt_r <= win_cnt_nxt;
      delay_cnt_r <= delay_cnt_nxt;
      lower_armed_r <= lower_armed_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // reset output
  // ----------------------------------------------------------------------
  // registered from the next state so the pin moves with the state, glitch free
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reset_n_r <= 1'h0;
      reset_oe_r <= 1'h1;
    end else begin
      reset_n_r <= (state_nxt == WWD_WATCH);
      reset_oe_r <= (state_nxt != WWD_WATCH);
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_out_follows_state;
    (state_r == WWD_WATCH) == reset_n_r and reset_oe_r == !reset_n_r;
  endproperty
  a_out_follows_state: assert property (p_out_follows_state)
    else $error("reset output does not match watchdog state");

  property p_timeout_reset;
    timeout_hit && lnk.supply_good |=> !reset_n_r && state_r == WWD_DELAY;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset)
    else $error("missed time-out did not assert reset");

  property p_early_reset;
    watching && lower_armed_r && lnk.trig_rise && win_cnt_r < lower_lim && lnk.supply_good
      |=> !reset_n_r ##1 !reset_n_r;
  endproperty
  a_early_reset: assert property (p_early_reset)
    else $error("early trigger did not assert reset");

  property p_supply_hold;
    !lnk.supply_good |=> !reset_n_r && state_r == WWD_HOLD;
  endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("reset released while supply low");

  property p_short_window;
    watching && tmode_r == WWD_TM_SHORT && win_cnt_r == SHORT_WIN && lnk.supply_good
      |=> state_r == WWD_DELAY;
  endproperty
  a_short_window: assert property (p_short_window)
    else $error("short window limit wrong");

  property p_long_window;
    watching && tmode_r == WWD_TM_LONG && win_cnt_r == LONG_WIN && lnk.supply_good
      |=> state_r == WWD_DELAY;
  endproperty
  a_long_window: assert property (p_long_window)
    else $error("long window limit wrong");

  property p_cap_window;
    watching && tmode_r == WWD_TM_CAP && lnk.supply_good &&
      32'(win_cnt_r) == (32'(cap_steps_r) + 32'd1) * 32'(CAP_STEP) |=> state_r == WWD_DELAY;
  endproperty
  a_cap_window: assert property (p_cap_window)
    else $error("capacitor window limit wrong");

  property p_cap_lower;
    cfg_done_r && tmode_r == WWD_TM_CAP |->
      64'(lower_lim) * 64'(ratio_fine_r ? RATIO_FINE_X10 : RATIO_COARSE_X10)
        >= 64'(upper_lim) * 64'hA &&
      64'(lower_lim - WIN_W'(1)) * 64'(ratio_fine_r ? RATIO_FINE_X10 : RATIO_COARSE_X10)
        < 64'(upper_lim) * 64'hA;
  endproperty
  a_cap_lower: assert property (p_cap_lower)
    else $error("capacitor lower boundary off ratio");

  property p_violation_restart;
    state_r == WWD_DELAY |-> win_cnt_r == '0 && !lower_armed_r;
  endproperty
  a_violation_restart: assert property (p_violation_restart)
    else $error("timer not reinitialised during reset");

  property p_first_trigger_free;
    ($rose(reset_n_r) |-> !lower_armed_r) and
    (watching && lnk.trig_rise && !lower_armed_r && !timeout_hit && lnk.supply_good
      |=> reset_n_r && lower_armed_r);
  endproperty
  a_first_trigger_free: assert property (p_first_trigger_free)
    else $error("lower boundary armed at release");

  // a clean pin edge reaches the core one cycle after the three-stage filter settles
  property p_trigger_latency;
    !watchdog_trigger_in [*4] ##1 watchdog_trigger_in [*4] |=> lnk.trig_rise;
  endproperty
  a_trigger_latency: assert property (p_trigger_latency)
    else $error("trigger edge not seen on the next cycle");

  property p_straps_held;
    cfg_done_r && $past(cfg_done_r) |-> $stable(tmode_r) && $stable(ratio_fine_r) &&
      $stable(cap_steps_r);
  endproperty
  a_straps_held: assert property (p_straps_held)
    else $error("strap setting moved after capture");

  property p_release_delay;
    state_r == WWD_DELAY && delay_done && supervise_ok |=> reset_n_r && state_r == WWD_WATCH;
  endproperty
  a_release_delay: assert property (p_release_delay)
    else $error("reset not released after delay");

  property p_no_early_release;
    state_r == WWD_DELAY && delay_cnt_r < RELEASE |=> !reset_n_r;
  endproperty
  a_no_early_release: assert property (p_no_early_release)
    else $error("reset released before delay elapsed");

  c_good_retrigger: cover property (good_trig && lower_armed_r);
  c_early_violation: cover property (early_hit);
  c_timeout: cover property (timeout_hit && lnk.supply_good);
  c_cap_mode_run: cover property (watching && tmode_r == WWD_TM_CAP && good_trig);
  c_supply_return: cover property (state_r == WWD_HOLD && supervise_ok);
endmodule

// file: tb/wwdsup_proc_model.sv
// Purpose: stand-in for the supervised processor that pulses the trigger pin
// Assumes: one core clock; fire is a one-cycle request from the bench
// Notes:   fire while a pulse is still running is ignored
`timescale 1ns/1ps
module wwdsup_proc_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic fire,
  output logic trig
);
  // --------------------------------------------------------------------
  // pulse shaper
  // --------------------------------------------------------------------
  // high four cycles, low at least four: both levels outlast the sync filter
  logic [2:0] cnt_r;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 3'h0;
      trig <= 1'h0;
    end else if (fire && cnt_r == 3'h0) begin
      // retrigger spacing is chosen by the bench, away from tolerance zones
      cnt_r <= 3'h7;
      trig <= 1'h1;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r - 3'h1;
      trig <= (cnt_r > 3'h4);
    end
  end
endmodule

// file: tb/wwdsup_tb.sv
// Purpose: self-checking bench for the window watchdog supervisor
// Assumes: shortened tick and window parameters, straps set before each reset
// Notes:   trigger gaps keep a few ticks of margin to absorb tick phase
`timescale 1ns/1ps
module testbench;
  import wwdsup_pkg::*;

  // --------------------------------------------------------------------
  // scaled timing
  // --------------------------------------------------------------------
  localparam int TK = 4;
  localparam int REL = 20;

  logic core_clk = 1'h0;
  logic rst = 1'h1;
  logic fire = 1'h0;
  logic supply_ok = 1'h0;
  logic [1:0] tsel = 2'h0;
  logic ratio = 1'h0;
  logic [CAP_W-1:0] cap = '0;
  logic trig;
  logic reset_n;
  logic reset_oe;
  logic armed;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  wwdsup_proc_model wwdsup_proc_model_i (
    .core_clk(core_clk),
    .rst(rst),
    .fire(fire),
    .trig(trig)
  );

  wwdsup_top #(
    .TICK_CYCLES_P(TK),
    .SHORT_WIN(WIN_W'(100)),
    .LONG_WIN(WIN_W'(400)),
    .SHORT_LOW_C(WIN_W'(10)),
    .SHORT_LOW_F(WIN_W'(4)),
    .LONG_LOW_C(WIN_W'(30)),
    .LONG_LOW_F(WIN_W'(8)),
    .CAP_STEP(WIN_W'(5)),
    .RELEASE(WIN_W'(REL))
  ) wwdsup_top_i (
    .core_clk(core_clk),
    .rst(rst),
    .watchdog_trigger_in(trig),
    .supply_threshold_ok(supply_ok),
    .timeout_select_strap(tsel),
    .ratio_select_strap(ratio),
    .cap_steps(cap),
    .reset_n_r(reset_n),
    .reset_oe_r(reset_oe),
    .lower_armed_r(armed)
  );

  always #12.5 core_clk = ~core_clk;

  // --------------------------------------------------------------------
  // hang guard and reporting
  // --------------------------------------------------------------------
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (fail_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // one trigger request, issued and ended on falling edges
  task automatic pulse();
    fire = 1'h1;
    @(negedge core_clk);
    fire = 1'h0;
  endtask

  // next trigger t ticks after the start of the previous one
  task automatic gap(input int t);
    wait_cyc(t * TK - 1);
    pulse();
  endtask

  // bounded wait for the reset output to reach a level
  task automatic wait_for(input logic lvl, input int n, input string what);
    int i;
    for (i = 0; i < n && reset_n !== lvl; i++) begin
      @(negedge core_clk);
    end
    chk(what, lvl, reset_n);
  endtask

  // --------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------
  // reset with straps in place, triggers while supply low, then supply returns
  task automatic bring_up(input logic [1:0] t, input logic r, input logic [CAP_W-1:0] c);
    rst = 1'h1;
    supply_ok = 1'h0;
    tsel = t;
    ratio = r;
    cap = c;
    wait_cyc(2);
    rst = 1'h0;
    repeat (4) gap(3);
    wait_cyc(10);
    chk("reset_n low supply", 1'h0, reset_n);
    chk("reset_oe low supply", 1'h1, reset_oe);
    supply_ok = 1'h1;
    wait_cyc((REL - 2) * TK);
    chk("reset_n release delay", 1'h0, reset_n);
    wait_for(1'h1, 4 * TK + 8, "reset_n after release delay");
    chk("lower_armed after release", 1'h0, armed);
  endtask

  // one strap setting: good, early, release, first trigger free, time-out
  task automatic cfg(input logic [1:0] t, input logic r, input logic [CAP_W-1:0] c,
                     input int win, input int early, input int good);
    bring_up(t, r, c);
    pulse();
    wait_cyc(10);
    chk("lower_armed first edge", 1'h1, armed);
    gap(good);
    gap(early);
    wait_cyc(2);
    chk("reset_n before sync", 1'h1, reset_n);
    wait_for(1'h0, 10, "reset_n early trigger");
    chk("reset_oe early trigger", 1'h1, reset_oe);
    chk("lower_armed cleared", 1'h0, armed);
    wait_cyc((REL - 3) * TK);
    chk("reset_n held release", 1'h0, reset_n);
    wait_for(1'h1, 4 * TK + 8, "reset_n released");
    wait_cyc(2);
    pulse();
    wait_cyc((win - 3) * TK);
    chk("reset_n before timeout", 1'h1, reset_n);
    chk("reset_oe before timeout", 1'h0, reset_oe);
    wait_for(1'h0, 6 * TK, "reset_n timeout");
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    cfg(2'h0, 1'h0, 12'h000, 100, 8, 13);
    cfg(2'h0, 1'h1, 12'h000, 100, 2, 7);
    cfg(2'h1, 1'h0, 12'h000, 400, 28, 33);
    cfg(2'h1, 1'h1, 12'h000, 400, 6, 11);
    cfg(2'h2, 1'h0, 12'h03B, 300, 9, 15);
    cfg(2'h2, 1'h1, 12'h03B, 300, 2, 8);
    cfg(2'h3, 1'h0, 12'h000, 100, 8, 13);
    close_out();
  end
endmodule
